// ==== flo_pkg.sv ====
package flo_pkg;

  // ==========================================================================
  // Widths and counts
  localparam int OFS_W_SMALL       = 16;
  localparam int OFS_W_LARGE       = 17;
  localparam int SER_BITS_SMALL    = 32;
  localparam int SER_BITS_LARGE    = 34;
  localparam int PAR_WORDS         = 6;
  localparam int PAR_WORDS_PER_OFS = 3;
  localparam int LANE_W            = 8;
  localparam int BUS_W             = 9;
  localparam int SETTLE_WCLK       = 2;
  localparam int SETTLE_RCLK       = 2;

  // ==========================================================================
  // Default offsets chosen at master reset by load-select and the two selects
  localparam logic [16:0] DEF_OFS_16383 = 17'h03FFF;
  localparam logic [16:0] DEF_OFS_8191  = 17'h01FFF;
  localparam logic [16:0] DEF_OFS_4095  = 17'h00FFF;
  localparam logic [16:0] DEF_OFS_2047  = 17'h007FF;
  localparam logic [16:0] DEF_OFS_1023  = 17'h003FF;
  localparam logic [16:0] DEF_OFS_511   = 17'h001FF;
  localparam logic [16:0] DEF_OFS_255   = 17'h000FF;
  localparam logic [16:0] DEF_OFS_127   = 17'h0007F;

  // ==========================================================================
  // Control pins, all active low as on the device
  typedef struct packed {
    logic offset_load_select_b;
    logic serial_shift_enable_b;
    logic write_enable_b;
    logic read_enable_b;
  } flo_ctl_t;

  typedef struct packed {
    logic almost_empty_flag_b;
    logic almost_full_flag_b;
    logic almost_empty_valid;
    logic almost_full_valid;
  } flo_flags_t;

  function automatic logic [16:0] flo_default_offset(input logic ld_b,
                                                     input logic [1:0] fsel);
    unique case ({ld_b, fsel})
      3'b010:  return DEF_OFS_16383;
      3'b001:  return DEF_OFS_8191;
      3'b011:  return DEF_OFS_4095;
      3'b110:  return DEF_OFS_2047;
      3'b100:  return DEF_OFS_1023;
      3'b101:  return DEF_OFS_511;
      3'b111:  return DEF_OFS_255;
      default: return DEF_OFS_127;
    endcase
  endfunction

endpackage

// ==== flo_wrap_counter.sv ====
`timescale 1ns/1ps
module flo_wrap_counter #(
  parameter int LIMIT = 6,
  parameter int CW    = $clog2(LIMIT)
) (
  // Clock and reset
  input  logic          clock_i,
  input  logic          rst_b_i,
  // Control
  input  logic          clear_i,
  input  logic          step_i,
  // Position
  output logic [CW-1:0] count_o,
  output logic          last_o
);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  if (LIMIT < 2) begin : g_bad_limit
    $error("flo_wrap_counter needs LIMIT of at least 2");
  end

  always_comb begin
    next_count = count;
    if (clear_i) begin
      next_count = '0;
    end else if (step_i) begin
      next_count = last_o ? '0 : count + CW'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign count_o = count;
  assign last_o  = (count == CW'(LIMIT - 1));

endmodule

// ==== flo_valid_track.sv ====
`timescale 1ns/1ps
module flo_valid_track #(
  parameter int SETTLE = 2
) (
  // Clock and reset
  input  logic clock_i,
  input  logic rst_b_i,
  // Events
  input  logic restore_i,
  input  logic invalidate_i,
  input  logic complete_i,
  input  logic tick_i,
  // Status
  output logic valid_o
);

  typedef enum logic [1:0] {
    FLO_ST_VALID  = 2'b00,
    FLO_ST_LOAD   = 2'b01,
    FLO_ST_SETTLE = 2'b10
  } flo_vstate_t;

  flo_vstate_t state;
  flo_vstate_t next_state;
  logic [1:0]  ticks;
  logic [1:0]  next_ticks;
  logic        next_valid;

  if (SETTLE < 1 || SETTLE > 3) begin : g_bad_settle
    $error("flo_valid_track serves SETTLE from 1 to 3");
  end

  always_comb begin
    next_state = state;
    next_ticks = ticks;
    if (restore_i) begin
      next_state = FLO_ST_VALID;
    end else if (complete_i) begin
      next_state = FLO_ST_SETTLE;
      next_ticks = '0;
    end else if (invalidate_i) begin
      next_state = FLO_ST_LOAD;
    end else begin
      unique case (state)
        FLO_ST_VALID, FLO_ST_LOAD: next_state = state;
        FLO_ST_SETTLE: begin
          if (tick_i) begin
            if (ticks == 2'(SETTLE - 1)) begin
              next_state = FLO_ST_VALID;
            end
            next_ticks = ticks + 2'h1;
          end
        end
        default: next_state = FLO_ST_LOAD;
      endcase
    end
    next_valid = (next_state == FLO_ST_VALID);
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state   <= FLO_ST_VALID;
      ticks   <= 2'h0;
      valid_o <= 1'b1;
    end else begin
      state   <= next_state;
      ticks   <= next_ticks;
      valid_o <= next_valid;
    end
  end

endmodule

// ==== flo_loader.sv ====
`timescale 1ns/1ps
module flo_loader #(
  parameter int OFS_W = flo_pkg::OFS_W_LARGE
) (
  // Clock (the write clock) and reset
  input  logic                     clock_i,
  input  logic                     rst_b_i,
  // Device pins
  input  logic                     master_reset_low_i,
  input  flo_pkg::flo_ctl_t        ctl_i,
  input  logic [1:0]               fsel_i,
  input  logic                     serial_in_i,
  input  logic                     read_clock_i,
  input  logic [flo_pkg::BUS_W-1:0] input_data_bus_i,
  // Fill level from the FIFO core
  input  logic [OFS_W:0]           fill_level_i,
  // Parallel readback and FIFO write path
  output logic [flo_pkg::BUS_W-1:0] output_data_bus_o,
  output logic                     fifo_write_o,
  output logic [flo_pkg::BUS_W-1:0] fifo_write_data_o,
  // Flags and serial mode
  output flo_pkg::flo_flags_t      flags_o,
  output logic                     serial_mode_o
);

  import flo_pkg::*;

  // ==========================================================================
  // Derived sizes
  localparam int SER_BITS = (OFS_W == OFS_W_SMALL) ? SER_BITS_SMALL : SER_BITS_LARGE;
  localparam int SCW      = $clog2(SER_BITS);
  localparam int PCW      = $clog2(PAR_WORDS);

  if (OFS_W != OFS_W_SMALL && OFS_W != OFS_W_LARGE) begin : g_bad_width
    $error("flo_loader serves only the two documented offset widths");
  end

  // ==========================================================================
  // Helpers
  // Which parallel portion of an offset a bit falls into.
  function automatic int part_of_bit(input int b);
    return b / LANE_W;
  endfunction

  function automatic int part_of_ptr(input logic [PCW-1:0] ptr);
    return int'(ptr) % PAR_WORDS_PER_OFS;
  endfunction

  function automatic logic ptr_is_full(input logic [PCW-1:0] ptr);
    return int'(ptr) >= PAR_WORDS_PER_OFS;
  endfunction

  // ==========================================================================
  // Strobe decode
  logic             mreset;
  logic             serial_mode;
  logic             next_serial_mode;
  logic             read_clock_d;
  logic             read_edge;
  logic             serial_shift;
  logic             par_write;
  logic             par_read;
  logic             fifo_wr;
  logic [SCW-1:0]   ser_pos;
  logic             ser_last;
  logic             ser_done;
  logic [PCW-1:0]   wr_ptr;
  logic             wr_last;
  logic [PCW-1:0]   rd_ptr;

  assign mreset    = ~master_reset_low_i;
  // The read clock is sampled like any other pin, so only its rising edge counts.
  assign read_edge = read_clock_i & ~read_clock_d;

  assign serial_shift = serial_mode & ~ctl_i.offset_load_select_b
                        & ~ctl_i.serial_shift_enable_b & ~mreset;
  assign par_write    = ~serial_mode & ~ctl_i.offset_load_select_b
                        & ~ctl_i.write_enable_b & ~mreset;
  assign par_read     = ~ctl_i.offset_load_select_b & ~ctl_i.read_enable_b
                        & read_edge & ~mreset;
  assign fifo_wr      = ctl_i.offset_load_select_b & ~ctl_i.write_enable_b & ~mreset;
  assign ser_done     = serial_shift & ser_last;

  // ==========================================================================
  // Position counters
  // The serial position only moves on a captured bit, so pauses resume in place.
  flo_wrap_counter #(
    .LIMIT (SER_BITS)
  ) u_ser_pos (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .clear_i (mreset),
    .step_i  (serial_shift),
    .count_o (ser_pos),
    .last_o  (ser_last)
  );

  flo_wrap_counter #(
    .LIMIT (PAR_WORDS)
  ) u_wr_ptr (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .clear_i (mreset),
    .step_i  (par_write),
    .count_o (wr_ptr),
    .last_o  (wr_last)
  );

  flo_wrap_counter #(
    .LIMIT (PAR_WORDS)
  ) u_rd_ptr (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .clear_i (mreset),
    .step_i  (par_read),
    .count_o (rd_ptr),
    .last_o  ()
  );

  // ==========================================================================
  // Offset registers
  logic [OFS_W-1:0] empty_side_offset;
  logic [OFS_W-1:0] full_side_offset;
  logic [OFS_W-1:0] next_empty_side_offset;
  logic [OFS_W-1:0] next_full_side_offset;
  logic [16:0]      reset_offset;

  assign reset_offset = flo_default_offset(ctl_i.offset_load_select_b, fsel_i);

  always_comb begin
    int idx;
    int wpart;
    idx   = int'(ser_pos);
    wpart = part_of_ptr(wr_ptr);
    next_serial_mode       = serial_mode;
    next_empty_side_offset = empty_side_offset;
    next_full_side_offset  = full_side_offset;
    if (mreset) begin
      next_serial_mode       = ctl_i.offset_load_select_b;
      next_empty_side_offset = reset_offset[OFS_W-1:0];
      next_full_side_offset  = reset_offset[OFS_W-1:0];
    end else if (serial_shift) begin
      // Empty offset takes the first half of the sequence, low bit first.
      if (idx < OFS_W) begin
        next_empty_side_offset[idx] = serial_in_i;
      end else begin
        next_full_side_offset[idx - OFS_W] = serial_in_i;
      end
    end else if (par_write) begin
      // Lanes that land above the offset width are simply dropped.
      for (int b = 0; b < OFS_W; b++) begin
        if (part_of_bit(b) == wpart) begin
          if (ptr_is_full(wr_ptr)) begin
            next_full_side_offset[b] = input_data_bus_i[b % LANE_W];
          end else begin
            next_empty_side_offset[b] = input_data_bus_i[b % LANE_W];
          end
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      serial_mode       <= 1'b0;
      empty_side_offset <= '0;
      full_side_offset  <= '0;
      read_clock_d      <= 1'b0;
    end else begin
      serial_mode       <= next_serial_mode;
      empty_side_offset <= next_empty_side_offset;
      full_side_offset  <= next_full_side_offset;
      read_clock_d      <= read_clock_i;
    end
  end

  // ==========================================================================
  // Parallel readback, FIFO write path and flag levels
  logic [BUS_W-1:0] rd_word;
  logic [BUS_W-1:0] next_output_data_bus;
  logic             next_fifo_write;
  logic [BUS_W-1:0] next_fifo_write_data;
  logic [OFS_W:0]   full_threshold;
  logic             next_almost_empty_b;
  logic             next_almost_full_b;
  logic             almost_empty_b;
  logic             almost_full_b;

  always_comb begin
    int rpart;
    rpart   = part_of_ptr(rd_ptr);
    rd_word = '0;
    for (int b = 0; b < OFS_W; b++) begin
      if (part_of_bit(b) == rpart) begin
        rd_word[b % LANE_W] = ptr_is_full(rd_ptr) ? full_side_offset[b]
                                                  : empty_side_offset[b];
      end
    end
    next_output_data_bus = par_read ? rd_word : output_data_bus_o;
    next_fifo_write      = fifo_wr;
    next_fifo_write_data = fifo_wr ? input_data_bus_i : fifo_write_data_o;
    full_threshold       = {1'b1, {OFS_W{1'b0}}} - {1'b0, full_side_offset};
    next_almost_full_b   = ~(fill_level_i >= full_threshold);
    next_almost_empty_b  = ~(fill_level_i <= {1'b0, empty_side_offset});
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      output_data_bus_o           <= '0;
      fifo_write_o                <= 1'b0;
      fifo_write_data_o           <= '0;
      almost_empty_b    <= 1'b0;
      almost_full_b     <= 1'b1;
    end else begin
      output_data_bus_o <= next_output_data_bus;
      fifo_write_o      <= next_fifo_write;
      fifo_write_data_o <= next_fifo_write_data;
      almost_empty_b    <= next_almost_empty_b;
      almost_full_b     <= next_almost_full_b;
    end
  end

  assign serial_mode_o = serial_mode;

  // ==========================================================================
  // Flag validity
  // In parallel mode each flag waits only for its own offset words.
  logic ae_inval;
  logic ae_done;
  logic af_inval;
  logic af_done;
  logic ae_valid;
  logic af_valid;

  assign ae_inval = serial_shift | (par_write & ~ptr_is_full(wr_ptr));
  assign af_inval = serial_shift | (par_write & ptr_is_full(wr_ptr));
  assign ae_done  = ser_done | (par_write & (part_of_ptr(wr_ptr) == PAR_WORDS_PER_OFS - 1)
                                & ~ptr_is_full(wr_ptr));
  assign af_done  = ser_done | (par_write & wr_last);

  flo_valid_track #(
    .SETTLE (SETTLE_RCLK)
  ) u_ae_valid (
    .clock_i      (clock_i),
    .rst_b_i      (rst_b_i),
    .restore_i    (mreset),
    .invalidate_i (ae_inval),
    .complete_i   (ae_done),
    .tick_i       (read_edge),
    .valid_o      (ae_valid)
  );

  flo_valid_track #(
    .SETTLE (SETTLE_WCLK)
  ) u_af_valid (
    .clock_i      (clock_i),
    .rst_b_i      (rst_b_i),
    .restore_i    (mreset),
    .invalidate_i (af_inval),
    .complete_i   (af_done),
    .tick_i       (1'b1),
    .valid_o      (af_valid)
  );

  // One driver for the whole flag word; every field is a flip-flop output.
  assign flags_o = {almost_empty_b, almost_full_b, ae_valid, af_valid};

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  property p_mode_pick;
    mreset |=> (serial_mode == $past(ctl_i.offset_load_select_b));
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("mode not taken at reset");

  property p_mode_hold;
    !mreset |=> $stable(serial_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed after reset");

  property p_first_bit;
    (serial_shift && ser_pos == '0) |=> (empty_side_offset[0] == $past(serial_in_i));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit misplaced");

  property p_shift_step;
    (serial_shift && !ser_last) |=> (ser_pos == $past(ser_pos) + SCW'(1));
  endproperty
  a_shift_step: assert property (p_shift_step) else $error("serial position skipped");

  property p_wrap;
    ser_done |=> (ser_pos == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("serial position did not wrap");

  property p_no_shift_paused;
    (serial_mode && !mreset && !ctl_i.offset_load_select_b && ctl_i.serial_shift_enable_b)
      |=> ($stable(empty_side_offset) && $stable(full_side_offset));
  endproperty
  a_no_shift_paused: assert property (p_no_shift_paused) else $error("offset changed");

  property p_load_invalid;
    (serial_shift && !ser_done) |=> (!flags_o.almost_full_valid && !flags_o.almost_empty_valid);
  endproperty
  a_load_invalid: assert property (p_load_invalid) else $error("flag valid mid-load");

  property p_af_late;
    af_done |=> !flags_o.almost_full_valid;
  endproperty
  a_af_late: assert property (p_af_late) else $error("almost-full valid too early");

  property p_af_on_time;
    af_done ##1 (!af_inval && !af_done && !mreset) [*2] |=> flags_o.almost_full_valid;
  endproperty
  a_af_on_time: assert property (p_af_on_time) else $error("almost-full valid late");

  property p_ae_on_read_edge;
    $rose(flags_o.almost_empty_valid) |-> ($past(read_edge) || $past(mreset));
  endproperty
  a_ae_on_read_edge: assert property (p_ae_on_read_edge) else $error("ae valid off edge");

  property p_fifo_write;
    fifo_wr |=> (fifo_write_o && fifo_write_data_o == $past(input_data_bus_i));
  endproperty
  a_fifo_write: assert property (p_fifo_write) else $error("fifo write lost");

  property p_ptr_reset;
    mreset |=> (wr_ptr == '0 && rd_ptr == '0);
  endproperty
  a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not at empty low");

  c_serial_done: cover property (ser_done);
  c_par_done:    cover property (par_write && wr_last);
  c_paused_load: cover property (serial_shift ##1 fifo_wr ##1 serial_shift);
  c_readback:    cover property (par_read && ptr_is_full(rd_ptr));

endmodule

// ==== flo_ctrl_model.sv ====
`timescale 1ns/1ps
module flo_ctrl_model (
  // Clock
  input  logic                      clock_i,
  // Device pins driven by the controller
  output logic                      master_reset_low_o,
  output flo_pkg::flo_ctl_t         ctl_o,
  output logic [1:0]                fsel_o,
  output logic                      serial_in_o,
  output logic                      read_clock_o,
  output logic [flo_pkg::BUS_W-1:0] data_o
);
  import flo_pkg::*;

  // ==========================================================================
  // Idle levels
  initial begin
    master_reset_low_o = 1'b1;
    ctl_o              = 4'hF;
    fsel_o             = 2'h0;
    serial_in_o        = 1'b0;
    read_clock_o       = 1'b0;
    data_o             = 9'h000;
  end

  // ==========================================================================
  // Controller operations, all changing pins just after a falling edge
  task automatic mres(input logic ld_b, input logic [1:0] fs);
    @(negedge clock_i);
    ctl_o              = {ld_b, 3'h7};
    fsel_o             = fs;
    master_reset_low_o = 1'b0;
    repeat (2) @(negedge clock_i);
    master_reset_low_o = 1'b1;
    ctl_o              = 4'hF;
  endtask

  // Bits go out from position lo to hi; the pins are released after the last.
  task automatic shift(input logic [33:0] bits, input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      @(negedge clock_i);
      ctl_o       = 4'h3;
      serial_in_o = bits[i];
    end
    @(negedge clock_i);
    ctl_o       = 4'hF;
    serial_in_o = ~serial_in_o;
  endtask

  // The serial line keeps toggling so that a pause that leaks shows up.
  task automatic pause(input logic [3:0] c, input int n);
    repeat (n) begin
      @(negedge clock_i);
      ctl_o       = c;
      serial_in_o = ~serial_in_o;
    end
  endtask

  task automatic fifo_wr(input logic [8:0] d);
    @(negedge clock_i);
    ctl_o  = 4'hD;
    data_o = d;
    @(negedge clock_i);
    ctl_o  = 4'hF;
    data_o = ~d;
  endtask

  task automatic par_wr(input logic [8:0] d);
    @(negedge clock_i);
    ctl_o  = 4'h5;
    data_o = d;
  endtask

  task automatic release_pins();
    @(negedge clock_i);
    ctl_o  = 4'hF;
    data_o = ~data_o;
  endtask

  task automatic rd();
    @(negedge clock_i);
    ctl_o        = 4'h6;
    read_clock_o = 1'b0;
    @(negedge clock_i);
    read_clock_o = 1'b1;
    @(negedge clock_i);
    read_clock_o = 1'b0;
    ctl_o        = 4'hF;
  endtask

  task automatic rpulse();
    @(negedge clock_i);
    read_clock_o = 1'b1;
    @(negedge clock_i);
    read_clock_o = 1'b0;
  endtask
endmodule

// ==== test_flo_loader.sv ====
`timescale 1ns/1ps
module test_flo_loader;
  import flo_pkg::*;

  logic                   clock_i;
  logic                   rst_b_i;
  logic                   master_reset_low;
  flo_ctl_t               ctl;
  logic [1:0]             fsel;
  logic                   serial_in;
  logic                   read_clock;
  logic [BUS_W-1:0]       din;
  logic [BUS_W-1:0]       dout;
  logic [BUS_W-1:0]       fwd;
  logic                   fwr;
  logic                   smode;
  flo_flags_t             flags;
  logic [OFS_W_LARGE:0]   fill_level;
  int                     bad_count;
  int                     checked;

  assign fill_level = '0;

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  flo_ctrl_model u_ctl (
    .clock_i            (clock_i),
    .master_reset_low_o (master_reset_low),
    .ctl_o              (ctl),
    .fsel_o             (fsel),
    .serial_in_o        (serial_in),
    .read_clock_o       (read_clock),
    .data_o             (din)
  );

  flo_loader #(.OFS_W(OFS_W_LARGE)) u_dut (
    .clock_i            (clock_i),
    .rst_b_i            (rst_b_i),
    .master_reset_low_i (master_reset_low),
    .ctl_i              (ctl),
    .fsel_i             (fsel),
    .serial_in_i        (serial_in),
    .read_clock_i       (read_clock),
    .input_data_bus_i   (din),
    .fill_level_i       (fill_level),
    .output_data_bus_o  (dout),
    .fifo_write_o       (fwr),
    .fifo_write_data_o  (fwd),
    .flags_o            (flags),
    .serial_mode_o      (smode)
  );

  // ==========================================================================
  // Checking helpers
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Six reads always, so the read pointer ends where it started.
  task automatic rd_ofs(input logic [16:0] e, input logic [16:0] f);
    logic [16:0] v;
    logic [8:0]  w;
    for (int i = 0; i < PAR_WORDS; i++) begin
      v = (i < PAR_WORDS_PER_OFS) ? e : f;
      case (i % PAR_WORDS_PER_OFS)
        0:       w = {1'b0, v[7:0]};
        1:       w = {1'b0, v[15:8]};
        default: w = {8'h00, v[16]};
      endcase
      u_ctl.rd();
      chk("readback word", {8'h00, w}, {8'h00, dout});
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    u_ctl.mres(1'b1, 2'h3);
    @(negedge clock_i);
    chk("serial mode", 17'h00001, {16'h0000, smode});
    chk("valids", 17'h00003, {15'h0000, flags.almost_empty_valid, flags.almost_full_valid});
    chk("flag levels", 17'h00001, {15'h0000, flags.almost_empty_flag_b, flags.almost_full_flag_b});
    rd_ofs(17'h000FF, 17'h000FF);
    $display("test reset done");
  endtask

  // Load broken by both kinds of pause and a FIFO write in the middle.
  task automatic t_serial(input logic [16:0] e, input logic [16:0] f);
    logic [33:0] bits;
    bits = {f, e};
    u_ctl.shift(bits, 0, 0);
    chk("valids after first bit", 17'h00000,
        {15'h0000, flags.almost_empty_valid, flags.almost_full_valid});
    u_ctl.shift(bits, 1, 9);
    u_ctl.pause(4'h7, 4);
    u_ctl.shift(bits, 10, 20);
    u_ctl.fifo_wr(9'h1A5);
    chk("fifo write pulse", 17'h00001, {16'h0000, fwr});
    chk("fifo write data", 17'h001A5, {8'h00, fwd});
    @(negedge clock_i);
    chk("fifo write pulse end", 17'h00000, {16'h0000, fwr});
    u_ctl.pause(4'hB, 3);
    u_ctl.shift(bits, 21, 32);
    chk("af valid before last bit", 17'h00000, {16'h0000, flags.almost_full_valid});
    u_ctl.shift(bits, 33, 33);
    chk("af valid at E", 17'h00000, {16'h0000, flags.almost_full_valid});
    @(negedge clock_i);
    chk("af valid at E+1", 17'h00000, {16'h0000, flags.almost_full_valid});
    @(negedge clock_i);
    chk("af valid at E+2", 17'h00001, {16'h0000, flags.almost_full_valid});
    chk("ae valid before reads", 17'h00000, {16'h0000, flags.almost_empty_valid});
    u_ctl.rpulse();
    @(negedge clock_i);
    chk("ae valid one read edge", 17'h00000, {16'h0000, flags.almost_empty_valid});
    u_ctl.rpulse();
    @(negedge clock_i);
    chk("ae valid two read edges", 17'h00001, {16'h0000, flags.almost_empty_valid});
    chk("serial mode kept", 17'h00001, {16'h0000, smode});
    rd_ofs(e, f);
    $display("test serial load done");
  endtask

  task automatic t_parallel(input logic [16:0] e, input logic [16:0] f);
    u_ctl.mres(1'b0, 2'h2);
    @(negedge clock_i);
    chk("parallel mode", 17'h00000, {16'h0000, smode});
    rd_ofs(17'h03FFF, 17'h03FFF);
    u_ctl.par_wr({1'b1, e[7:0]});
    u_ctl.par_wr({1'b1, e[15:8]});
    u_ctl.par_wr({8'hAA, e[16]});
    u_ctl.par_wr({1'b1, f[7:0]});
    u_ctl.par_wr({1'b1, f[15:8]});
    u_ctl.par_wr({8'h54, f[16]});
    u_ctl.release_pins();
    u_ctl.shift(34'h3_FFFF_FFFF, 0, 5);
    rd_ofs(e, f);
    $display("test parallel load done");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    bad_count = 0;
    checked   = 0;
    rst_b_i   = 1'b0;
    repeat (20) @(negedge clock_i);
    rst_b_i = 1'b1;
    t_reset();
    t_serial(17'h1A5C3, 17'h0B3E7);
    t_serial(17'h00005, 17'h1FFFE);
    t_parallel(17'h15A3C, 17'h0C0DE);
    end_of_test();
  end
endmodule
